/* logic/rule_table_defines.svh */
// Purpose: Offsets, field positions, reset values and counts for the rule table access block
// Assumes: Byte-wide register port, one access per clock
// Notes: Included by the package and the block
`ifndef RULE_TABLE_DEFINES_SVH
`define RULE_TABLE_DEFINES_SVH

// ****************************************
// Direct register addresses
// ****************************************
`define SEL_REG_ADDR 8'h6E
`define OFS_REG_ADDR 8'h6F
`define DATA_REG_ADDR 8'hA0

// ****************************************
// Indirect offsets inside the rule table space
// ****************************************
`define OFS_WORD_LAST 8'h0D
`define OFS_BE_UPPER 8'h10
`define OFS_BE_LOWER 8'h11
`define OFS_ACCESS_CTRL 8'h12
`define OFS_RING_MISS 8'h13

// ****************************************
// Select register fields
// ****************************************
`define SEL_TABLE_MSB 7
`define SEL_TABLE_LSB 5
`define SEL_TABLE_RULE 3'h2
`define SEL_PORT_MSB 3
`define SEL_PORT_LSB 0

// ****************************************
// Access control fields and reset values
// ****************************************
`define CTRL_WR_DONE_BIT 6
`define CTRL_RD_DONE_BIT 5
`define CTRL_DIR_BIT 4
`define CTRL_ENTRY_MSB 3
`define CTRL_ENTRY_LSB 0
`define CTRL_DONE_RESET 1'h1
`define CTRL_DIR_RESET 1'h0
`define RING_MISS_RESET 1'h0
`define BE_UPPER_WIDTH 6

// ****************************************
// Documented sizes
// ****************************************
`define NUM_PORTS_DEF 5
`define NUM_ENTRIES_DEF 16
`define WORD_BYTES_DEF 14

`endif

/* logic/rule_table_pkg.sv */
// Purpose: Types shared by the rule table access block
// Assumes: Defines header present on the include path
// Notes: One-hot transfer states
package rule_table_pkg;
	`include "rule_table_defines.svh"

	// Transfer engine states, one-hot
	typedef enum logic [1:0] {
		XFER_IDLE = 2'h1,
		XFER_BUSY = 2'h2
	} xfer_state_t;

	// Byte-wide data
	typedef logic [7:0] byte_t;
endpackage

/* logic/rule_table_access.sv */
// Purpose: Indirect access to per-port rule tables through select, offset and data registers
// Assumes: Host accesses are synchronous to SYS_CLK, at most one of read or write per cycle
// Notes: An entry transfer moves one byte per clock; every bit of state sits in one struct
// Behaviour
// - Write done flag low during write, resets high
// - Read done flag low during read, resets high
// - Direction bit: one writes table, zero reads
// - Low four bits choose one of sixteen entries
// - Miss bit one: single entry, match is miss
// - Miss bit zero, reset: rule set, hit
// - Mask at 10h upper, 11h lower bytes
// - Each mask bit governs one word byte
// - Data register bursts over consecutive offsets
// - Host loads holding buffer before write launch
// - Write copies only enabled bytes into entry
`timescale 1ns/100ps
// Guarded, so a second inclusion after the package is harmless
`include "rule_table_defines.svh"

module rule_table_access
	import rule_table_pkg::*;
#(
	parameter int NUM_PORTS = `NUM_PORTS_DEF,
	parameter int NUM_ENTRIES = `NUM_ENTRIES_DEF,
	parameter int WORD_BYTES = `WORD_BYTES_DEF
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	// Host register port
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire rule_table_pkg::byte_t REG_WDATA,
	input wire logic REG_RD,
	output rule_table_pkg::byte_t REG_RDATA,
	// Per-port ring redundancy miss mode
	output logic [NUM_PORTS-1:0] RING_MISS_MODE,
	// Transfer engine activity
	output logic XFER_BUSY_FLAG
);
	import rule_table_pkg::*;

	// ****************************************
	// Elaboration checks
	// ****************************************
	// Logic below is built for the documented word and table geometry
	if (NUM_PORTS < 1 || NUM_PORTS > 15 || NUM_ENTRIES != 16 || WORD_BYTES != 14) begin : g_bad_params
		$error("rule_table_access: unsupported geometry");
	end

	localparam int PW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;
	localparam logic [3:0] LAST_BYTE = 4'(WORD_BYTES - 1);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [NUM_PORTS-1:0][NUM_ENTRIES-1:0][WORD_BYTES-1:0][7:0] table_mem; // Rule words
		logic [NUM_PORTS-1:0][WORD_BYTES-1:0][7:0] hold; // Holding buffers
		logic [NUM_PORTS-1:0][WORD_BYTES-1:0] mask; // Byte enables
		logic [NUM_PORTS-1:0] wr_done; // Write completed flags
		logic [NUM_PORTS-1:0] rd_done; // Read completed flags
		logic [NUM_PORTS-1:0] dir; // Transfer direction
		logic [NUM_PORTS-1:0][3:0] entry; // Chosen entry
		logic [NUM_PORTS-1:0] ring_miss; // Redundancy miss mode
		byte_t sel; // Indirect select
		byte_t ofs; // Indirect offset
		byte_t rdata; // Read answer
		xfer_state_t xst; // Transfer engine state
		logic [PW-1:0] xport; // Port being transferred
		logic [3:0] cnt; // Byte being moved
	} state_t;

	state_t st_ff;
	state_t nxt_st;

	// Decoded select fields
	logic sel_ok;
	logic [3:0] sel_port;
	logic [PW-1:0] pidx;

	// ****************************************
	// Select decode
	// ****************************************
	// Only the rule table code with a port in range opens the data window
	always_comb begin
		sel_port = st_ff.sel[`SEL_PORT_MSB:`SEL_PORT_LSB];
		pidx = PW'(sel_port - 4'h1);
		sel_ok = (st_ff.sel[`SEL_TABLE_MSB:`SEL_TABLE_LSB] == `SEL_TABLE_RULE) && (sel_port != 4'h0)
			&& (32'(sel_port) <= NUM_PORTS);
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		// Host writes
		if (REG_WR) begin
			unique case (REG_ADDR)
				`SEL_REG_ADDR: begin
					nxt_st.sel = REG_WDATA;
				end
				`OFS_REG_ADDR: begin
					nxt_st.ofs = REG_WDATA;
				end
				`DATA_REG_ADDR: begin
					if (sel_ok) begin
						if (st_ff.ofs <= `OFS_WORD_LAST) begin
							// Holding buffer byte
							nxt_st.hold[pidx][st_ff.ofs[3:0]] = REG_WDATA;
						end else if (st_ff.ofs == `OFS_BE_UPPER) begin
							nxt_st.mask[pidx][WORD_BYTES-1 -: `BE_UPPER_WIDTH] =
								REG_WDATA[`BE_UPPER_WIDTH-1:0];
						end else if (st_ff.ofs == `OFS_BE_LOWER) begin
							nxt_st.mask[pidx][7:0] = REG_WDATA;
						end else if (st_ff.ofs == `OFS_ACCESS_CTRL) begin
							// Launch refused while an earlier transfer runs
							if (st_ff.xst == XFER_IDLE) begin
								nxt_st.dir[pidx] = REG_WDATA[`CTRL_DIR_BIT];
								nxt_st.entry[pidx] = REG_WDATA[`CTRL_ENTRY_MSB:`CTRL_ENTRY_LSB];
								if (REG_WDATA[`CTRL_DIR_BIT]) begin
									nxt_st.wr_done[pidx] = 1'b0;
								end else begin
									nxt_st.rd_done[pidx] = 1'b0;
								end
								nxt_st.xst = XFER_BUSY;
								nxt_st.xport = pidx;
								nxt_st.cnt = 4'h0;
							end
						end else if (st_ff.ofs == `OFS_RING_MISS) begin
							nxt_st.ring_miss[pidx] = REG_WDATA[0];
						end
						// Offset steps so a burst walks consecutive bytes
						nxt_st.ofs = st_ff.ofs + 8'h01;
					end
				end
				default: begin
					// Unmapped addresses ignored
				end
			endcase
		end else if (REG_RD) begin
			// Host reads, answer registered
			unique case (REG_ADDR)
				`SEL_REG_ADDR: begin
					nxt_st.rdata = st_ff.sel;
				end
				`OFS_REG_ADDR: begin
					nxt_st.rdata = st_ff.ofs;
				end
				`DATA_REG_ADDR: begin
					nxt_st.rdata = 8'h00;
					if (sel_ok) begin
						if (st_ff.ofs <= `OFS_WORD_LAST) begin
							nxt_st.rdata = st_ff.hold[pidx][st_ff.ofs[3:0]];
						end else if (st_ff.ofs == `OFS_BE_UPPER) begin
							nxt_st.rdata = {2'h0, st_ff.mask[pidx][WORD_BYTES-1 -: `BE_UPPER_WIDTH]};
						end else if (st_ff.ofs == `OFS_BE_LOWER) begin
							nxt_st.rdata = st_ff.mask[pidx][7:0];
						end else if (st_ff.ofs == `OFS_ACCESS_CTRL) begin
							// Reserved bit 7 reads zero
							nxt_st.rdata = {1'b0, st_ff.wr_done[pidx], st_ff.rd_done[pidx],
								st_ff.dir[pidx], st_ff.entry[pidx]};
						end else if (st_ff.ofs == `OFS_RING_MISS) begin
							nxt_st.rdata = {7'h00, st_ff.ring_miss[pidx]};
						end
						nxt_st.ofs = st_ff.ofs + 8'h01;
					end
				end
				default: begin
					// Unmapped addresses read zero
					nxt_st.rdata = 8'h00;
				end
			endcase
		end

		// Transfer engine, one byte per clock; it wins over a host write to the same byte
		unique case (st_ff.xst)
			XFER_IDLE: begin
				// Waiting for a launch
			end
			XFER_BUSY: begin
				// Mask bit 13 governs byte 0 and bit 0 governs byte 13
				if (st_ff.mask[st_ff.xport][LAST_BYTE - st_ff.cnt]) begin
					if (st_ff.dir[st_ff.xport]) begin
						nxt_st.table_mem[st_ff.xport][st_ff.entry[st_ff.xport]][st_ff.cnt] =
							st_ff.hold[st_ff.xport][st_ff.cnt];
					end else begin
						nxt_st.hold[st_ff.xport][st_ff.cnt] =
							st_ff.table_mem[st_ff.xport][st_ff.entry[st_ff.xport]][st_ff.cnt];
					end
				end
				if (st_ff.cnt == LAST_BYTE) begin
					// Flag rises on the same edge that moves the last byte
					if (st_ff.dir[st_ff.xport]) begin
						nxt_st.wr_done[st_ff.xport] = 1'b1;
					end else begin
						nxt_st.rd_done[st_ff.xport] = 1'b1;
					end
					nxt_st.xst = XFER_IDLE;
				end else begin
					nxt_st.cnt = st_ff.cnt + 4'h1;
				end
			end
		endcase
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			st_ff <= '0;
			st_ff.wr_done <= {NUM_PORTS{`CTRL_DONE_RESET}};
			st_ff.rd_done <= {NUM_PORTS{`CTRL_DONE_RESET}};
			st_ff.dir <= {NUM_PORTS{`CTRL_DIR_RESET}};
			st_ff.ring_miss <= {NUM_PORTS{`RING_MISS_RESET}};
			st_ff.xst <= XFER_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// Outputs, straight from flops
	// ****************************************
	assign REG_RDATA = st_ff.rdata;
	assign RING_MISS_MODE = st_ff.ring_miss;
	assign XFER_BUSY_FLAG = st_ff.xst[1];
endmodule

/* testbench/rule_table_access_sva.sv */
// Purpose: Port-level checks of the rule table access block
// Assumes: Select and offset are shadowed from host writes
// Notes: Bound into the design
`timescale 1ns/100ps
module rule_table_access_sva
	import rule_table_pkg::*;
#(
	parameter int NUM_PORTS = 5
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	// Host register port
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire rule_table_pkg::byte_t REG_WDATA,
	input wire logic REG_RD,
	input wire rule_table_pkg::byte_t REG_RDATA,
	// Status
	input wire logic [NUM_PORTS-1:0] RING_MISS_MODE,
	input wire logic XFER_BUSY_FLAG
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	// Shadow select, offset and busy run length
	logic [7:0] sel_ff, ofs_ff, run_ff;
	logic ok, dat, go;
	// Select names the rule table and a real port
	assign ok = sel_ff[7:5] == 3'h2 && sel_ff[3:0] != 4'h0 && sel_ff[3:0] <= 4'(NUM_PORTS);
	assign dat = (REG_WR || REG_RD) && REG_ADDR == 8'hA0 && ok;
	assign go = REG_WR && dat && ofs_ff == 8'h12 && !XFER_BUSY_FLAG;
	// Track host writes; data accesses step the offset
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			sel_ff <= 8'h00;
			ofs_ff <= 8'h00;
			run_ff <= 8'h00;
		end else begin
			if (REG_WR && REG_ADDR == 8'h6E) sel_ff <= REG_WDATA;
			if (REG_WR && REG_ADDR == 8'h6F) ofs_ff <= REG_WDATA;
			else if (dat) ofs_ff <= ofs_ff + 8'h01;
			run_ff <= XFER_BUSY_FLAG ? run_ff + 8'h01 : 8'h00;
		end
	end
	busy_start_a: assert property (go |=> XFER_BUSY_FLAG)
		else $error("launch did not start transfer");
	busy_cause_a: assert property ($rose(XFER_BUSY_FLAG) |-> $past(go))
		else $error("transfer started without launch");
	busy_len_a: assert property ($fell(XFER_BUSY_FLAG) |-> run_ff == 8'h0E)
		else $error("transfer length wrong");
	sel_read_a: assert property (REG_RD && !REG_WR && REG_ADDR == 8'h6E |=> REG_RDATA == sel_ff)
		else $error("select readback wrong");
	ofs_read_a: assert property (REG_RD && !REG_WR && REG_ADDR == 8'h6F |=> REG_RDATA == ofs_ff)
		else $error("offset readback wrong");
	bad_sel_a: assert property (REG_RD && !REG_WR && REG_ADDR == 8'hA0 && !ok |=> REG_RDATA == 8'h00)
		else $error("refused data read not zero");
	unmapped_a: assert property (REG_RD && !REG_WR && !(REG_ADDR inside {8'h6E, 8'h6F, 8'hA0})
		|=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!$past(REG_RD) |-> $stable(REG_RDATA))
		else $error("read data moved without read");
	miss_hold_a: assert property (!$past(REG_WR) |-> $stable(RING_MISS_MODE))
		else $error("miss mode moved without write");
endmodule
bind rule_table_access rule_table_access_sva #(.NUM_PORTS(NUM_PORTS)) u_sva (.SYS_CLK(SYS_CLK),
	.RESET_N(RESET_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA), .RING_MISS_MODE(RING_MISS_MODE), .XFER_BUSY_FLAG(XFER_BUSY_FLAG));

/* testbench/host_model.sv */
// Purpose: Host side of the register port
// Assumes: Strobes change on falling edges
// Notes: One idle cycle between accesses
`timescale 1ns/100ps
module host_model (
	// Clock
	input wire logic SYS_CLK,
	// Register port
	output logic [7:0] REG_ADDR,
	output logic REG_WR,
	output logic [7:0] REG_WDATA,
	output logic REG_RD
);
	// Quiet port at time zero
	initial begin
		REG_ADDR = 8'h00;
		REG_WR = 1'b0;
		REG_WDATA = 8'h00;
		REG_RD = 1'b0;
	end
	// One access held across one rising edge
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge SYS_CLK);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = w;
		REG_RD = !w;
		@(negedge SYS_CLK);
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		// Inverted after release so stale values never look valid
		REG_ADDR = ~a;
		REG_WDATA = ~d;
	endtask
	// Table select: 4n to write, 5n to read
	task sel(input logic [3:0] p, input logic r);
		acc(1'b1, 8'h6E, {3'h2, r, p});
	endtask
	// Indirect offset
	task ind(input logic [7:0] o);
		acc(1'b1, 8'h6F, o);
	endtask
endmodule

/* testbench/tb.sv */
// Purpose: Self-checking bench for the rule table access block
// Assumes: Fixed 14-cycle transfers
// Notes: Reads queue their expected bytes
`timescale 1ns/100ps
module tb;
	import rule_table_pkg::*;
	logic SYS_CLK;
	logic RESET_N;
	// Host strobes come from the partner model, status from the design
	wire logic [7:0] REG_ADDR;
	wire logic [7:0] REG_WDATA;
	wire logic REG_WR;
	wire logic REG_RD;
	logic pend = 1'b0;
	wire byte_t REG_RDATA;
	wire logic [4:0] RING_MISS_MODE;
	wire logic XFER_BUSY_FLAG;
	byte_t q[$], d[14];
	int n_fail = 0, compares = 0, cyc = 0;
	logic [31:0] seed = 32'd18;
	always #20 SYS_CLK = ~SYS_CLK;
	rule_table_access u_rule_table_access (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
		.REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
		.RING_MISS_MODE(RING_MISS_MODE), .XFER_BUSY_FLAG(XFER_BUSY_FLAG));
	host_model u_host (.SYS_CLK(SYS_CLK), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
		.REG_WDATA(REG_WDATA), .REG_RD(REG_RD));
	// Xorshift source for rule bytes
	function byte_t xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task chk(input byte_t s, input byte_t e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, s, e);
		end
	endtask
	task test_done;
		if (n_fail == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task rd(input logic [7:0] a, input byte_t e);
		q.push_back(e);
		u_host.acc(1'b0, a, 8'h00);
	endtask
	task wr(input logic [7:0] a, input byte_t v);
		u_host.acc(1'b1, a, v);
	endtask
	// Poll first, launch, try a second launch while busy, see the flag low mid-run, then high
	task xfer(input byte_t c, input byte_t pre, input byte_t mid, input byte_t fin);
		u_host.ind(8'h12);
		rd(8'hA0, pre);
		u_host.ind(8'h12);
		wr(8'hA0, c);
		// Refused while the engine runs: entry, direction and flags must not move
		u_host.ind(8'h12);
		wr(8'hA0, 8'h00);
		u_host.ind(8'h12);
		rd(8'hA0, mid);
		repeat (14) @(negedge SYS_CLK);
		u_host.ind(8'h12);
		rd(8'hA0, fin);
	endtask
	// Read answer lands on the same edge that samples the read
	always @(posedge SYS_CLK) pend <= REG_RD && !REG_WR;
	always @(negedge SYS_CLK) if (pend) chk(REG_RDATA, q.pop_front());
	// Hang guard, far above the few hundred cycles needed
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc > 3000) begin
			n_fail++;
			test_done();
		end
	end
	initial begin
		SYS_CLK = 1'b0;
		RESET_N = 1'b0;
		repeat (8) @(posedge SYS_CLK);
		@(negedge SYS_CLK) RESET_N <= 1'b1;
		u_host.sel(4'h1, 1'b0);
		rd(8'h6E, 8'h41);
		u_host.ind(8'h12);
		rd(8'hA0, 8'h60);
		rd(8'hA0, 8'h00);
		rd(8'h6F, 8'h14);
		rd(8'h55, 8'h00);
		u_host.ind(8'h13);
		wr(8'hA0, 8'h01);
		chk({3'h0, RING_MISS_MODE}, 8'h01);
		u_host.ind(8'h13);
		rd(8'hA0, 8'h01);
		wr(8'h6E, 8'h47);
		rd(8'hA0, 8'h00);
		rd(8'h6F, 8'h14);
		u_host.sel(4'h5, 1'b0);
		u_host.ind(8'h00);
		foreach (d[i]) begin
			d[i] = xs();
			wr(8'hA0, d[i]);
		end
		u_host.ind(8'h10);
		wr(8'hA0, 8'h15);
		wr(8'hA0, 8'h55);
		xfer(8'h1F, 8'h60, 8'h3F, 8'h7F);
		u_host.ind(8'h00);
		foreach (d[i]) wr(8'hA0, 8'h00);
		wr(8'hA0, 8'h00);
		wr(8'hA0, 8'h00);
		wr(8'hA0, 8'h3F);
		wr(8'hA0, 8'hFF);
		u_host.sel(4'h5, 1'b1);
		xfer(8'h0F, 8'h7F, 8'h4F, 8'h6F);
		u_host.ind(8'h00);
		foreach (d[i]) rd(8'hA0, i[0] ? d[i] : 8'h00);
		repeat (2) @(negedge SYS_CLK);
		test_done();
	end
endmodule
